// [rtl/init_host.sv]
// Host controller: power-down pin sequencing and init sequences A and B
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
module init_host #(
  parameter int READY_CYCLES = pll_init_pkg::READY_CYC,
  parameter int HARD_RESET_CYCLES = pll_init_pkg::HARD_RESET_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Board status
  input wire logic supplies_ok,
  input wire logic tmds_clk_stable,
  output logic hdmi_input_en,
  // Link to bridge
  pll_link_if.host link
);
  import pll_init_pkg::*;

  typedef enum logic [6:0] {
    S_HRST = 7'b0000001,
    S_OFF = 7'b0000010,
    S_BOOT = 7'b0000100,
    S_IDLE = 7'b0001000,
    S_TMDS = 7'b0010000,
    S_ISSUE = 7'b0100000,
    S_ACK = 7'b1000000
  } state_type;

  state_type state_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [3:0] step_ff, last_ff;
  logic rd_phase_ff, pdb_ff, req_ff, we_ff, hdmi_en_ff;
  logic [7:0] addr_ff, wdata_ff, rd_val_ff;
  logic power_on_ff, pend_a_ff, pend_b_ff, pend_hr_ff;
  logic done_a_ff, done_b_ff;
  logic pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;

  //----------------------------------------------------------------
  // Step table
  //----------------------------------------------------------------
  // Returns {op, address, value} of one register access
  function automatic logic [17:0] step_op(input logic [3:0] idx);
    case (idx)
      // [R7] clear auto link PLL reset
      4'h0: step_op = {OP_CLR, REG_FREQ_CFG, 8'(1 << FREQ_RST_EN_BIT)};
      // [R8] shorten spurious bus events
      4'h1: step_op = {OP_WRITE, REG_EVT_FILT, EVT_FILT_VAL};
      // [R9] stop video in blanking
      4'h2: step_op = {OP_SET, REG_VID_CFG, 8'(1 << BLANK_BLOCK_BIT)};
      // [R5] HDMI PLL pulse, reserved bits zero
      4'h3: step_op = {OP_WRITE, REG_PAGE_SEL, PAGE_HDMI};
      4'h4: step_op = {OP_WRITE, REG_OFFSET_SEL, OFS_PLL_CTRL};
      4'h5: step_op = {OP_WRITE, REG_PAGE_DATA, PLL_RST_SET};
      4'h6: step_op = {OP_WRITE, REG_PAGE_DATA, PLL_RST_CLR};
      // [R6] link PLL pulse, reserved bits zero
      4'h7: step_op = {OP_WRITE, REG_PAGE_SEL, PAGE_LINK};
      4'h8: step_op = {OP_WRITE, REG_OFFSET_SEL, OFS_PLL_CTRL};
      4'h9: step_op = {OP_WRITE, REG_PAGE_DATA, PLL_RST_SET};
      4'hA: step_op = {OP_WRITE, REG_PAGE_DATA, PLL_RST_CLR};
      default: step_op = {OP_WRITE, 8'h00, 8'h00};
    endcase
  endfunction

  wire [17:0] cur = step_op(step_ff);
  wire [1:0] cur_op = cur[17:16];
  wire [7:0] cur_addr = cur[15:8];
  wire [7:0] cur_val = cur[7:0];
  wire is_rmw = (cur_op != OP_WRITE);
  // [R4] read-modify-write keeps other bits
  wire [7:0] rmw_val = (cur_op == OP_CLR) ? (rd_val_ff & ~cur_val) :
                                            (rd_val_ff | cur_val);
  wire [CNT_W-1:0] hr_end = CNT_W'(HARD_RESET_CYCLES - 1);
  wire [CNT_W-1:0] rdy_end = CNT_W'(READY_CYCLES - 1);
  wire [CNT_W-1:0] tmds_end = CNT_W'(TMDS_STABLE_CYC - 1);
  wire [CNT_W-1:0] cnt_inc = cnt_ff + 1'b1;

  //----------------------------------------------------------------
  // APB decode
  //----------------------------------------------------------------
  wire setup = psel && !penable;
  wire acc_wr = psel && penable && pready_ff && pwrite;
  wire hit_ctrl = (paddr == APB_CTRL);
  wire hit_stat = (paddr == APB_STATUS);
  wire ctrl_wr = acc_wr && hit_ctrl;
  wire busy = (state_ff != S_IDLE);
  wire [31:0] status_word = {16'h0, rd_val_ff, 1'b0, busy, done_b_ff,
                             done_a_ff, hdmi_en_ff, pdb_ff,
                             (state_ff == S_BOOT), (state_ff == S_IDLE)};
  wire [31:0] ctrl_word = {28'h0, pend_hr_ff, pend_b_ff, pend_a_ff,
                           power_on_ff};
  wire [31:0] rd_word = hit_ctrl ? ctrl_word :
                        hit_stat ? status_word : 32'h0;
  // Sequencer takes a pending command only when idle
  wire take_hr = (state_ff == S_IDLE) && (pend_hr_ff || !power_on_ff);
  wire take_a = (state_ff == S_IDLE) && !take_hr && pend_a_ff;
  wire take_b = (state_ff == S_IDLE) && !take_hr && !pend_a_ff && pend_b_ff;

  // Zero-wait answer: data ready by the first access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !hit_ctrl && !hit_stat;
      if (setup) prdata_ff <= rd_word;
    end
  end

  // Command flags: a new request wins over the clear by the sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_on_ff <= 1'b0;
      pend_a_ff <= 1'b0;
      pend_b_ff <= 1'b0;
      pend_hr_ff <= 1'b0;
    end else begin
      if (ctrl_wr) power_on_ff <= pwdata[CTRL_POWER_ON];
      if (ctrl_wr && pwdata[CTRL_START_A]) pend_a_ff <= 1'b1;
      else if (take_a || take_hr) pend_a_ff <= 1'b0;
      if (ctrl_wr && pwdata[CTRL_START_B]) pend_b_ff <= 1'b1;
      else if (take_b || take_hr) pend_b_ff <= 1'b0;
      if (ctrl_wr && pwdata[CTRL_HARD_RST]) pend_hr_ff <= 1'b1;
      else if (take_hr) pend_hr_ff <= 1'b0;
    end
  end

  //----------------------------------------------------------------
  // Sequencer
  //----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= S_HRST;
      cnt_ff <= '0;
      step_ff <= 4'h0;
      last_ff <= 4'h0;
      rd_phase_ff <= 1'b0;
      pdb_ff <= 1'b0;
      hdmi_en_ff <= 1'b0;
      req_ff <= 1'b0;
      we_ff <= 1'b0;
      addr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      rd_val_ff <= 8'h00;
      done_a_ff <= 1'b0;
      done_b_ff <= 1'b0;
    end else begin
      case (state_ff)
        // [R13] hold power-down low long enough
        S_HRST: begin
          cnt_ff <= cnt_inc;
          if (cnt_ff >= hr_end) state_ff <= S_OFF;
        end
        // [R11] release only after supplies settle
        S_OFF: begin
          cnt_ff <= '0;
          if (power_on_ff && supplies_ok) begin
            pdb_ff <= 1'b1;
            state_ff <= S_BOOT;
          end
        end
        // [R12] bus quiet after release
        S_BOOT: begin
          cnt_ff <= cnt_inc;
          if (cnt_ff >= rdy_end) begin
            hdmi_en_ff <= 1'b1;
            state_ff <= S_IDLE;
          end
        end
        S_IDLE: begin
          cnt_ff <= '0;
          if (take_hr) begin
            pdb_ff <= 1'b0;
            hdmi_en_ff <= 1'b0;
            done_a_ff <= 1'b0;
            done_b_ff <= 1'b0;
            state_ff <= S_HRST;
          end else if (take_a) begin
            step_ff <= SEQ_A_FIRST;
            last_ff <= SEQ_A_LAST;
            rd_phase_ff <= 1'b1;
            state_ff <= S_ISSUE;
          end else if (take_b) begin
            state_ff <= S_TMDS;
          end
        end
        // [R10] [R14] wait for stable TMDS clock
        S_TMDS: begin
          cnt_ff <= tmds_clk_stable ? cnt_inc : '0;
          if (tmds_clk_stable && cnt_ff >= tmds_end) begin
            step_ff <= SEQ_B_FIRST;
            last_ff <= SEQ_B_LAST;
            rd_phase_ff <= 1'b1;
            state_ff <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          req_ff <= 1'b1;
          addr_ff <= cur_addr;
          we_ff <= !(is_rmw && rd_phase_ff);
          wdata_ff <= is_rmw ? rmw_val : cur_val;
          state_ff <= S_ACK;
        end
        S_ACK: begin
          if (link.ack) begin
            req_ff <= 1'b0;
            if (!we_ff) begin
              rd_val_ff <= link.rdata;
              rd_phase_ff <= 1'b0;
              state_ff <= S_ISSUE;
            end else if (step_ff == last_ff) begin
              if (last_ff == SEQ_A_LAST) done_a_ff <= 1'b1;
              else done_b_ff <= 1'b1;
              state_ff <= S_IDLE;
            end else begin
              step_ff <= step_ff + 4'h1;
              rd_phase_ff <= 1'b1;
              state_ff <= S_ISSUE;
            end
          end
        end
        default: state_ff <= S_HRST;
      endcase
    end
  end

  // Outputs straight from flip-flops
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign hdmi_input_en = hdmi_en_ff;
  assign link.power_down_bar_pin = pdb_ff;
  assign link.req = req_ff;
  assign link.we = we_ff;
  assign link.addr = addr_ff;
  assign link.wdata = wdata_ff;
endmodule // init_host

// [rtl/pll_init_pkg.sv]
// Constants shared by the bridge register bank and its init controller
//------------------------------------------------------------------
// How it works
// [R1] Hidden pages reached only via three windows
// [R2] Page 0x10 bit 4 resets HDMI PLL
// [R3] Page 0x14 bit 4 resets link PLL
// [R4] Host writes reserved PLL bits as zero
// [R5] HDMI PLL reset: 0x10,0x49,0x10,0x00
// [R6] Link PLL reset: 0x14,0x49,0x10,0x00
// [R7] Bit 5 of 0x5B clear: no auto reset
// [R8] Host writes 0x02 into register 0x16
// [R9] Bit 4 of 0x04 blocks blanking video
// [R10] Sequence B only after TMDS clock stable
// [R11] Release power-down after supplies, then HDMI
// [R12] Wait 2 ms after release before access
// [R13] Hard reset holds power-down low 2 ms
// [R14] TMDS clock stable 1 us before resets
// [R15] Data window writes page/offset target at once
// [R16] Both PLL reset bits read 0 after reset
//------------------------------------------------------------------
package pll_init_pkg;
  // Main map window registers and other main registers
  localparam logic [7:0] REG_PAGE_SEL = 8'h40;
  localparam logic [7:0] REG_OFFSET_SEL = 8'h41;
  localparam logic [7:0] REG_PAGE_DATA = 8'h42;
  localparam logic [7:0] REG_VID_CFG = 8'h04;
  localparam logic [7:0] REG_EVT_FILT = 8'h16;
  localparam logic [7:0] REG_FREQ_CFG = 8'h5B;
  // Hidden pages and PLL control offset
  localparam logic [7:0] PAGE_HDMI = 8'h10;
  localparam logic [7:0] PAGE_LINK = 8'h14;
  localparam logic [7:0] OFS_PLL_CTRL = 8'h49;
  // Field positions
  localparam int PLL_RST_BIT = 4;
  localparam int FREQ_RST_EN_BIT = 5;
  localparam int BLANK_BLOCK_BIT = 4;
  // Data values
  localparam logic [7:0] PLL_RST_SET = 8'h10;
  localparam logic [7:0] PLL_RST_CLR = 8'h00;
  localparam logic [7:0] EVT_FILT_VAL = 8'h02;
  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] FREQ_CFG_RESET = 8'h20;
  // Timing
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int T_READY_MS = 2;
  localparam int T_HARD_RESET_MS = 2;
  localparam int T_TMDS_STABLE_US = 1;
  localparam int READY_CYC = T_READY_MS * (CLK_FREQ_HZ / 1000);
  localparam int HARD_RESET_CYC = T_HARD_RESET_MS * (CLK_FREQ_HZ / 1000);
  localparam int TMDS_STABLE_CYC =
    (T_TMDS_STABLE_US * CLK_FREQ_HZ + 999_999) / 1_000_000;
  localparam int CNT_W = 20;
  // Controller APB map
  localparam logic [11:0] APB_CTRL = 12'h000;
  localparam logic [11:0] APB_STATUS = 12'h004;
  localparam int CTRL_POWER_ON = 0;
  localparam int CTRL_START_A = 1;
  localparam int CTRL_START_B = 2;
  localparam int CTRL_HARD_RST = 3;
  // Sequence step table layout
  localparam logic [3:0] SEQ_A_FIRST = 4'h0;
  localparam logic [3:0] SEQ_A_LAST = 4'h2;
  localparam logic [3:0] SEQ_B_FIRST = 4'h3;
  localparam logic [3:0] SEQ_B_LAST = 4'hA;
  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_CLR = 2'h1,
    OP_SET = 2'h2
  } op_type;
endpackage

// [rtl/pll_link_if.sv]
// Power-down pin and register access channel between host and bridge
`timescale 1ns/10ps
interface pll_link_if;
  logic power_down_bar_pin;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  modport host (
    output power_down_bar_pin, req, we, addr, wdata,
    input ack, rdata
  );
  modport dev (
    input power_down_bar_pin, req, we, addr, wdata,
    output ack, rdata
  );
endinterface

// [rtl/bridge_regs.sv]
// Bridge register bank with paged window and PLL reset outputs
`timescale 1ns/10ps
module bridge_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link to host
  pll_link_if.dev link,
  // Bridge core side
  input wire logic freq_change,
  output logic hdmi_pll_rst,
  output logic link_pll_rst,
  output logic blank_video_block,
  output logic [7:0] evt_filt_cfg
);
  import pll_init_pkg::*;

  //----------------------------------------------------------------
  // Decode
  //----------------------------------------------------------------
  logic [7:0] page_sel_ff, ofs_sel_ff, vid_cfg_ff, evt_ff, freq_cfg_ff;
  logic hdmi_rst_bit_ff, link_rst_bit_ff, ack_ff;
  logic [7:0] rdata_ff;
  wire alive = link.power_down_bar_pin;
  wire take = alive && link.req && !ack_ff;
  wire wr = take && link.we;
  // [R1] window decode only
  wire sel_hdmi = (page_sel_ff == PAGE_HDMI) && (ofs_sel_ff == OFS_PLL_CTRL);
  wire sel_link = (page_sel_ff == PAGE_LINK) && (ofs_sel_ff == OFS_PLL_CTRL);
  wire wr_data = wr && (link.addr == REG_PAGE_DATA);
  wire [7:0] hdmi_view = {3'h0, hdmi_rst_bit_ff, 4'h0};
  wire [7:0] link_view = {3'h0, link_rst_bit_ff, 4'h0};
  wire [7:0] page_view = sel_hdmi ? hdmi_view :
                         sel_link ? link_view : 8'h00;
  wire [7:0] rd_mux =
    (link.addr == REG_PAGE_SEL) ? page_sel_ff :
    (link.addr == REG_OFFSET_SEL) ? ofs_sel_ff :
    (link.addr == REG_PAGE_DATA) ? page_view :
    (link.addr == REG_VID_CFG) ? vid_cfg_ff :
    (link.addr == REG_EVT_FILT) ? evt_ff :
    (link.addr == REG_FREQ_CFG) ? freq_cfg_ff : 8'h00;
  // [R7] auto reset only when enabled
  wire auto_rst = freq_change && freq_cfg_ff[FREQ_RST_EN_BIT];

  //----------------------------------------------------------------
  // Registers; power-down low acts as hard reset
  //----------------------------------------------------------------
  // [R16] PLL bits clear on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_sel_ff <= REG_RESET;
      ofs_sel_ff <= REG_RESET;
      vid_cfg_ff <= REG_RESET;
      evt_ff <= REG_RESET;
      freq_cfg_ff <= FREQ_CFG_RESET;
      hdmi_rst_bit_ff <= 1'b0;
      link_rst_bit_ff <= 1'b0;
    end else if (!alive) begin
      page_sel_ff <= REG_RESET;
      ofs_sel_ff <= REG_RESET;
      vid_cfg_ff <= REG_RESET;
      evt_ff <= REG_RESET;
      freq_cfg_ff <= FREQ_CFG_RESET;
      hdmi_rst_bit_ff <= 1'b0;
      link_rst_bit_ff <= 1'b0;
    end else if (wr) begin
      // [R15] selections persist between accesses
      if (link.addr == REG_PAGE_SEL) page_sel_ff <= link.wdata;
      if (link.addr == REG_OFFSET_SEL) ofs_sel_ff <= link.wdata;
      if (link.addr == REG_VID_CFG) vid_cfg_ff <= link.wdata;
      if (link.addr == REG_EVT_FILT) evt_ff <= link.wdata;
      if (link.addr == REG_FREQ_CFG) freq_cfg_ff <= link.wdata;
      // [R2] HDMI PLL reset bit
      if (wr_data && sel_hdmi) hdmi_rst_bit_ff <= link.wdata[PLL_RST_BIT];
      // [R3] link PLL reset bit
      if (wr_data && sel_link) link_rst_bit_ff <= link.wdata[PLL_RST_BIT];
    end
  end

  // Handshake: one ack per held request, data frozen with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      ack_ff <= take;
      if (take) rdata_ff <= rd_mux;
    end
  end

  // Core outputs registered so they cannot glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdmi_pll_rst <= 1'b0;
      link_pll_rst <= 1'b0;
      blank_video_block <= 1'b0;
      evt_filt_cfg <= REG_RESET;
    end else begin
      hdmi_pll_rst <= hdmi_rst_bit_ff;
      link_pll_rst <= link_rst_bit_ff | auto_rst;
      // [R9] blanking video suppress
      blank_video_block <= vid_cfg_ff[BLANK_BLOCK_BIT];
      evt_filt_cfg <= evt_ff;
    end
  end

  assign link.ack = ack_ff;
  assign link.rdata = rdata_ff;
endmodule // bridge_regs

// [verification/pll_link_monitor.sv]
// Checker for the host-to-bridge channel and the PLL reset outputs
`timescale 1ns/10ps
module pll_link_monitor #(
  parameter int READY_CYCLES = pll_init_pkg::READY_CYC,
  parameter int HARD_RESET_CYCLES = pll_init_pkg::HARD_RESET_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Channel signals
  input wire logic power_down_bar_pin,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  // Bridge core outputs
  input wire logic hdmi_pll_rst,
  input wire logic link_pll_rst
);
  import pll_init_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  //------------------------------------------------------------
  // Helper state
  //------------------------------------------------------------
  logic [7:0] page_ff;
  logic [7:0] ofs_ff;
  logic hdmi_done_ff;
  logic [19:0] hi_cnt_ff;
  logic [19:0] lo_cnt_ff;
  wire wr_done = req && ack && we;
  wire data_wr = wr_done && addr == REG_PAGE_DATA;
  wire pll_hit = ofs_ff == OFS_PLL_CTRL &&
    (page_ff == PAGE_HDMI || page_ff == PAGE_LINK);
  // Window selections as last written on the channel; cleared only by presetn, not while the pin is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_ff <= 8'h00;
      ofs_ff <= 8'h00;
    end else if (wr_done && addr == REG_PAGE_SEL) begin
      page_ff <= wdata;
    end else if (wr_done && addr == REG_OFFSET_SEL) begin
      ofs_ff <= wdata;
    end
  end
  // Pin level durations; saturate so a long run never wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt_ff <= 20'h0;
      lo_cnt_ff <= 20'h0;
      hdmi_done_ff <= 1'b0;
    end else if (power_down_bar_pin) begin
      lo_cnt_ff <= 20'h0;
      hi_cnt_ff <= hi_cnt_ff + {19'h0, hi_cnt_ff != 20'hFFFFF};
      hdmi_done_ff <= hdmi_done_ff || (data_wr && pll_hit &&
        page_ff == PAGE_HDMI && wdata == PLL_RST_CLR);
    end else begin
      hi_cnt_ff <= 20'h0;
      lo_cnt_ff <= lo_cnt_ff + {19'h0, lo_cnt_ff != 20'hFFFFF};
      hdmi_done_ff <= 1'b0;
    end
  end
  //------------------------------------------------------------
  // Sequences and assertions
  //------------------------------------------------------------
  sequence s_hdmi_set;
    data_wr && pll_hit && page_ff == PAGE_HDMI && wdata == PLL_RST_SET;
  endsequence
  sequence s_hdmi_clr;
    data_wr && pll_hit && page_ff == PAGE_HDMI && wdata == PLL_RST_CLR;
  endsequence
  sequence s_link_set;
    data_wr && pll_hit && page_ff == PAGE_LINK && wdata == PLL_RST_SET;
  endsequence
  ack_follows_req_a: assert property (req && !ack &&
    power_down_bar_pin |=> ack)
    else $error("request not acknowledged one cycle later");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("acknowledge longer than one cycle");
  no_ack_off_a: assert property (!power_down_bar_pin |=> !ack)
    else $error("acknowledge while held in hard reset");
  req_hold_a: assert property (req && !ack |=> req && $stable(addr))
    else $error("request dropped before acknowledge");
  boot_wait_a: assert property (req |->
    int'(hi_cnt_ff) >= READY_CYCLES - 1)
    else $error("access before boot wait ended");
  hard_len_a: assert property ($rose(power_down_bar_pin) |->
    int'(lo_cnt_ff) >= HARD_RESET_CYCLES - 1)
    else $error("hard reset pulse too short");
  hdmi_set_a: assert property (s_hdmi_set |->
    ##[1:2] hdmi_pll_rst)
    else $error("hdmi pll reset did not follow set");
  hdmi_clr_a: assert property (s_hdmi_clr |->
    ##[1:2] !hdmi_pll_rst)
    else $error("hdmi pll reset did not release");
  link_set_a: assert property (s_link_set |->
    ##[1:2] link_pll_rst)
    else $error("link pll reset did not follow set");
  link_order_a: assert property (s_link_set |-> hdmi_done_ff)
    else $error("link pll reset before hdmi pll reset");
  reserved_zero_a: assert property (data_wr && pll_hit |->
    (wdata & 8'hEF) == 8'h00)
    else $error("reserved pll control bits written nonzero");
endmodule // pll_link_monitor

// [verification/test_paged_pll_reset_init_control.sv]
// Self-checking bench for the init controller and bridge pair
`timescale 1ns/10ps
module test_paged_pll_reset_init_control;
  import pll_init_pkg::*;
  typedef struct {logic [31:0] mask; logic [31:0] data; logic err;} note_type;
  localparam int FAST = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic supplies_ok, tmds_clk_stable, hdmi_input_en, freq_change;
  logic hdmi_pll_rst, link_pll_rst, blank_video_block;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lfsr_ff, rd_val;
  logic [7:0] evt_filt_cfg;
  int err_count, num_checks, hdmi_rises, link_rises, link_base;
  note_type notes[$];
  note_type note;
  pll_link_if link_bus();
  init_host #(.READY_CYCLES(FAST), .HARD_RESET_CYCLES(FAST)) u_init_host (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supplies_ok(supplies_ok),
    .tmds_clk_stable(tmds_clk_stable), .hdmi_input_en(hdmi_input_en),
    .link(link_bus.host));
  bridge_regs u_bridge_regs (.pclk(pclk), .presetn(presetn),
    .link(link_bus.dev), .freq_change(freq_change),
    .hdmi_pll_rst(hdmi_pll_rst), .link_pll_rst(link_pll_rst),
    .blank_video_block(blank_video_block), .evt_filt_cfg(evt_filt_cfg));
  pll_link_monitor #(.READY_CYCLES(FAST), .HARD_RESET_CYCLES(FAST)) u_mon (
    .pclk(pclk), .presetn(presetn),
    .power_down_bar_pin(link_bus.power_down_bar_pin), .req(link_bus.req),
    .we(link_bus.we), .addr(link_bus.addr), .wdata(link_bus.wdata),
    .ack(link_bus.ack), .hdmi_pll_rst(hdmi_pll_rst),
    .link_pll_rst(link_pll_rst));
  //------------------------------------------------------------
  // Helpers
  //------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %0h expected %0h", $time, got, exp);
    end
  endtask
  // One APB transfer; the expected answer is noted before it starts
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, input logic [31:0] m, input logic [31:0] e,
      input logic er);
    notes.push_back('{m, e, er});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_val = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Poll a status bit; the watchdog and the count bound the wait
  task automatic wait_st(input int b);
    rd_val = '0;
    for (int i = 0; i < 300 && rd_val[b] !== 1'b1; i++) begin
      apb(1'b0, APB_STATUS, '0, '0, '0, 1'b0);
    end
    chk(32'(rd_val[b]), 32'h1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  //------------------------------------------------------------
  // Processes
  //------------------------------------------------------------
  // Clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Compare each completed transfer with the oldest note
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      note = notes.pop_front();
      chk(prdata & note.mask, note.data);
      chk(32'(pslverr), 32'(note.err));
    end
  end
  // Count reset pulses seen on each PLL
  always @(posedge hdmi_pll_rst) hdmi_rises++;
  always @(posedge link_pll_rst) link_rises++;
  // Watchdog, sized well above the whole sequence
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, supplies_ok} = 5'h00;
    {tmds_clk_stable, freq_change} = 2'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    lfsr_ff = 32'hADA29C2D;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'({hdmi_pll_rst, link_pll_rst}), 32'h0);
    lfsr_ff = lfsr_next(lfsr_ff);
    apb(1'b1, {lfsr_ff[11:4], 4'h8}, lfsr_ff, '0, '0, 1'b1);
    apb(1'b0, {lfsr_ff[11:4], 4'h8}, '0, 32'hFFFFFFFF, '0, 1'b1);
    // Power on with supplies not yet settled: pin must stay low
    apb(1'b1, APB_CTRL, 32'h1, '0, '0, 1'b0);
    repeat (2 * FAST) @(posedge pclk);
    chk(32'(link_bus.power_down_bar_pin), 32'h0);
    supplies_ok <= 1'b1;
    wait_st(0);
    chk(32'(hdmi_input_en), 32'h1);
    freq_change <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(32'(link_pll_rst), 32'h1);
    freq_change <= 1'b0;
    // Sequence A, then the frequency change must be ignored
    apb(1'b1, APB_CTRL, 32'h3, '0, '0, 1'b0);
    wait_st(4);
    chk(32'(evt_filt_cfg), 32'(EVT_FILT_VAL));
    chk(32'(blank_video_block), 32'h1);
    apb(1'b0, APB_STATUS, '0, 32'h18, 32'h18, 1'b0);
    freq_change <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(32'(link_pll_rst), 32'h0);
    freq_change <= 1'b0;
    // Sequence B with a TMDS clock that settles too briefly first
    apb(1'b1, APB_CTRL, 32'h5, '0, '0, 1'b0);
    // The pulse from the frequency test above must not be counted
    link_base = link_rises;
    lfsr_ff = lfsr_next(lfsr_ff);
    tmds_clk_stable <= 1'b1;
    repeat (1 + int'(lfsr_ff[4:0])) @(posedge pclk);
    tmds_clk_stable <= 1'b0;
    repeat (5) @(posedge pclk);
    chk(32'(hdmi_rises), 32'h0);
    tmds_clk_stable <= 1'b1;
    wait_st(5);
    chk(32'(hdmi_rises), 32'h1);
    chk(32'(link_rises - link_base), 32'h1);
    chk(32'({hdmi_pll_rst, link_pll_rst}), 32'h0);
    // Hard reset clears the bridge, then boot runs again
    apb(1'b1, APB_CTRL, 32'h9, '0, '0, 1'b0);
    for (int i = 0; i < 50 && link_bus.power_down_bar_pin !== 1'b0; i++) begin
      @(posedge pclk);
    end
    chk(32'(link_bus.power_down_bar_pin), 32'h0);
    wait_st(0);
    chk(32'({blank_video_block, evt_filt_cfg}), 32'h0);
    chk(32'({hdmi_pll_rst, link_pll_rst}), 32'h0);
    // Power off while idle takes the hard reset path as well
    apb(1'b1, APB_CTRL, 32'h0, '0, '0, 1'b0);
    apb(1'b0, APB_CTRL, '0, 32'hF, 32'h0, 1'b0);
    chk(32'(link_bus.power_down_bar_pin), 32'h0);
    apb(1'b1, APB_CTRL, 32'h1, '0, '0, 1'b0);
    wait_st(0);
    tally_and_finish();
  end
endmodule // test_paged_pll_reset_init_control
